// >>> pkg/sideband_pkg.sv
`default_nettype none
package sideband_pkg;
    localparam int DATA_W       = 64;
    localparam int QUAL_W       = 4;
    localparam int FIFO_DEPTH   = 32;
    // qualifier bit positions on the user bits of the transmit stream
    localparam int QB_DIGEST    = 0;
    localparam int QB_POISON    = 1;
    localparam int QB_STREAMED  = 2;
    localparam int QB_DISCONT   = 3;
    // length of a self-generated packet in beats
    localparam int INT_PKT_BEATS = 3;
    localparam logic [DATA_W-1:0] INT_PKT_WORD = 64'h0000_0000_4a00_0001;
    localparam logic [31:0]       DIGEST_WORD  = 32'h0000_0000;
    // device-side status word layout
    localparam int ST_POISON  = 0;
    localparam int ST_DIGEST  = 1;
    localparam int ST_STREAM  = 2;
    localparam int ST_GRANTED = 3;
    localparam int ST_W       = 4;
    // controller register offsets
    localparam logic [3:0] A_CTRL    = 4'h0;
    localparam logic [3:0] A_DATA_LO = 4'h1;
    localparam logic [3:0] A_DATA_HI = 4'h2;
    localparam logic [3:0] A_QUAL    = 4'h3;
    localparam logic [3:0] A_STATUS  = 4'h4;
    localparam int CT_PUSH  = 0;
    localparam int CT_LAST  = 1;
    localparam int CT_GRANT = 2;
    localparam int CT_AUTO  = 3;
endpackage
`default_nettype wire

// >>> pkg/sideband_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sideband_if import sideband_pkg::*; ();
    logic [DATA_W-1:0] tdata;
    logic              tvalid;
    logic              tready;
    logic              tlast;
    logic [QUAL_W-1:0] tuser;
    logic              int_req;
    logic              int_gnt;
    modport dev (input tdata, tvalid, tlast, tuser, int_gnt, output tready, int_req);
    modport usr (output tdata, tvalid, tlast, tuser, int_gnt, input tready, int_req);
endinterface
`default_nettype wire

// >>> src/sb_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sb_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic [AW:0]      cnt_reg;
    wire              do_wr = in_valid && in_ready;
    wire              do_rd = out_valid && out_ready;
    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rp_reg];
    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[wp_reg] <= in_data;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (do_wr)
                wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
            if (do_rd)
                rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule
`default_nettype wire

// >>> src/tx_sideband_dev.sv
// What this block does
// R01 - user sends streamed packets without gaps
// R02 - streamed packets start before fully written
// R03 - raise request when internal packet ready
// R04 - drop request between serviced internal packets
// R05 - user grants in answer to request
// R06 - no grant: user packets go first
// R07 - one-cycle grant: internal packet next
// R08 - remember grant while no buffer space
// R09 - user may hold grant high always
// R10 - poison on any beat marks packet
// R11 - never poison a streamed packet; code drops poison only on qualifier words with the streamed bit set
// R12 - digest bit at first beat appends CRC
// R13 - qualifiers sampled only on valid-ready beats
`timescale 1ns/10ps
`default_nettype none
module tx_sideband_dev import sideband_pkg::*; #(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    sideband_if.dev                LNK,
    input  wire logic              INT_PEND,
    input  wire logic              LINK_READY,
    output logic       [WIDTH-1:0] LINK_DATA,
    output logic                   LINK_VALID,
    output logic                   LINK_LAST,
    output logic       [ST_W-1:0]  LINK_STATUS,
    output logic                   INT_TAKEN
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_USER = 4'b0010,
        S_INT  = 4'b0100,
        S_DIG  = 4'b1000
    } out_state_t;

    out_state_t  state_reg, state_next;
    logic        req_reg, req_next;
    logic        gnt_reg, gnt_next;
    logic        cool_reg;
    logic [1:0]  beat_reg;
    logic        sof_reg, poison_reg, digest_reg, stream_reg;
    logic [ST_W-1:0] pkt_reg;
    logic [1:0]  pkts_reg;
    logic [WIDTH-1:0] data_reg;
    logic        valid_reg, last_reg;

    wire in_beat = LNK.tvalid && LNK.tready; // R13
    wire [WIDTH:0] f_out;
    wire f_valid;
    wire f_ready;
    wire f_in_ready;
    sb_fifo #(.WIDTH(WIDTH + 1), .DEPTH(DEPTH)) sb_fifo_inst (
        .clk       (CLK),
        .rst       (RST),
        .in_data   ({LNK.tlast, LNK.tdata}),
        .in_valid  (LNK.tvalid),
        .in_ready  (f_in_ready),
        .out_data  (f_out),
        .out_valid (f_valid),
        .out_ready (f_ready)
    );
    assign LNK.tready = f_in_ready;

    // per-packet qualifiers of the packet being written
    wire poison_now = poison_reg || LNK.tuser[QB_POISON]; // R10
    wire digest_now = sof_reg ? LNK.tuser[QB_DIGEST] : digest_reg; // R12
    wire stream_now = sof_reg ? LNK.tuser[QB_STREAMED] : stream_reg;
    // a streamed packet may leave as soon as its first beat is queued;
    // others wait until the whole packet is held in the buffer
    wire user_ok = f_valid && (stream_reg || pkts_reg != '0); // R02
    wire user_done = (state_reg == S_USER) && f_valid && LINK_READY && f_out[WIDTH];
    assign f_ready = (state_reg == S_USER) && LINK_READY;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sof_reg    <= 1'b1;
            poison_reg <= 1'b0;
            digest_reg <= 1'b0;
            stream_reg <= 1'b0;
            pkt_reg    <= '0;
            pkts_reg   <= '0;
        end
        else
        begin
            if (in_beat) // R13
            begin
                sof_reg    <= LNK.tlast;
                poison_reg <= LNK.tlast ? 1'b0 : poison_now;
                digest_reg <= digest_now;
                stream_reg <= stream_now;
                if (LNK.tlast)
                    pkt_reg <= {gnt_reg, stream_now, digest_now, poison_now};
            end
            pkts_reg <= pkts_reg + 2'(in_beat && LNK.tlast) - 2'(user_done);
        end
    end

    // request stands until its packet leaves, so a captured grant never goes stale;
    // it then rests low so that each request starts on a rise
    wire serviced = (state_reg == S_INT) && LINK_READY && beat_reg == 2'(INT_PKT_BEATS-1);
    assign req_next = !serviced && (req_reg || (INT_PEND && !cool_reg)); // R03 R04
    // grant captured once, held until the internal packet leaves
    assign gnt_next = serviced ? 1'b0 : (gnt_reg || (LNK.int_gnt && req_reg)); // R08
    assign LNK.int_req = req_reg;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:
                if (gnt_reg && req_reg)
                    state_next = S_INT; // R07
                else if (user_ok)
                    state_next = S_USER; // R06
            S_USER:
                if (user_done)
                    state_next = pkt_reg[ST_DIGEST] ? S_DIG : S_IDLE; // R12
            S_INT:
                if (serviced)
                    state_next = S_IDLE;
            S_DIG:
                if (LINK_READY)
                    state_next = S_IDLE;
            default:
                state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg <= S_IDLE;
            req_reg   <= 1'b0;
            gnt_reg   <= 1'b0;
            cool_reg  <= 1'b0;
            beat_reg  <= '0;
        end
        else
        begin
            state_reg <= state_next;
            req_reg   <= req_next;
            gnt_reg   <= gnt_next;
            cool_reg  <= serviced; // R04
            if (state_reg == S_INT && LINK_READY)
                beat_reg <= serviced ? '0 : beat_reg + 2'd1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            data_reg    <= '0;
            valid_reg   <= 1'b0;
            last_reg    <= 1'b0;
            LINK_STATUS <= '0;
            INT_TAKEN   <= 1'b0;
        end
        else
        begin
            INT_TAKEN <= serviced;
            if (LINK_READY)
            begin
                valid_reg <= 1'b0;
                last_reg  <= 1'b0;
                case (state_reg)
                    S_USER:
                        if (f_valid)
                        begin
                            data_reg    <= f_out[WIDTH-1:0];
                            valid_reg   <= 1'b1;
                            last_reg    <= f_out[WIDTH] && !pkt_reg[ST_DIGEST];
                            LINK_STATUS <= pkt_reg; // R10
                        end
                    S_INT:
                    begin
                        data_reg  <= INT_PKT_WORD;
                        valid_reg <= 1'b1;
                        last_reg  <= serviced;
                    end
                    S_DIG:
                    begin
                        data_reg  <= WIDTH'(DIGEST_WORD);
                        valid_reg <= 1'b1;
                        last_reg  <= 1'b1;
                    end
                    default:
                        valid_reg <= 1'b0;
                endcase
            end
        end
    end
    assign LINK_DATA  = data_reg;
    assign LINK_VALID = valid_reg;
    assign LINK_LAST  = last_reg;
endmodule
`default_nettype wire

// >>> src/tx_sideband_usr.sv
`timescale 1ns/10ps
`default_nettype none
module tx_sideband_usr import sideband_pkg::*; (
    input  wire logic        CLK,
    input  wire logic        RST,
    sideband_if.usr          LNK,
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA
);
    logic [DATA_W-1:0] data_reg;
    logic [QUAL_W-1:0] qual_reg;
    logic              valid_reg, last_reg, auto_reg, gnt_reg, rise_reg, req_d_reg;
    wire ctrl_wr = WR && ADDR == A_CTRL;
    // qualifier words with the streamed bit set carry no poison bit
    wire [QUAL_W-1:0] qual_ok = WDATA[QB_STREAMED] ? (WDATA[QUAL_W-1:0] & ~(QUAL_W'(1) << QB_POISON))
                                                    : WDATA[QUAL_W-1:0]; // R11
    wire req_rise = LNK.int_req && !req_d_reg; // R05
    assign LNK.tdata   = data_reg;
    assign LNK.tvalid  = valid_reg;
    assign LNK.tlast   = last_reg;
    assign LNK.tuser   = qual_reg;
    assign LNK.int_gnt = auto_reg || gnt_reg; // R09
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            data_reg  <= '0;
            qual_reg  <= '0;
            valid_reg <= 1'b0;
            last_reg  <= 1'b0;
            auto_reg  <= 1'b1;
            gnt_reg   <= 1'b0;
            rise_reg  <= 1'b0;
            req_d_reg <= 1'b0;
            RDATA     <= '0;
        end
        else
        begin
            req_d_reg <= LNK.int_req;
            // a new rise wins over a grant written in the same cycle
            rise_reg  <= req_rise || (rise_reg && !(ctrl_wr && WDATA[CT_GRANT]));
            gnt_reg   <= ctrl_wr && WDATA[CT_GRANT]; // R05
            if (valid_reg && LNK.tready) // R01
                valid_reg <= 1'b0;
            if (ctrl_wr)
            begin
                auto_reg <= WDATA[CT_AUTO];
                if (WDATA[CT_PUSH])
                begin
                    valid_reg <= 1'b1;
                    last_reg  <= WDATA[CT_LAST];
                end
            end
            if (WR && ADDR == A_DATA_LO)
                data_reg[31:0] <= WDATA;
            if (WR && ADDR == A_DATA_HI)
                data_reg[63:32] <= WDATA;
            if (WR && ADDR == A_QUAL)
                qual_reg <= qual_ok;
            if (RD)
                case (ADDR)
                    A_CTRL:   RDATA <= {28'h0, auto_reg, 3'h0};
                    A_QUAL:   RDATA <= {28'h0, qual_reg};
                    A_STATUS: RDATA <= {28'h0, rise_reg, LNK.int_req, LNK.tready, valid_reg};
                    default:  RDATA <= 32'h0;
                endcase
            else
                RDATA <= 32'h0;
        end
    end
endmodule
`default_nettype wire

// >>> bench/sideband_checker.sv
`timescale 1ns/10ps
`default_nettype none
module sideband_checker import sideband_pkg::*; (
    input wire logic              CLK,
    input wire logic              RST,
    input wire logic              tvalid,
    input wire logic              tready,
    input wire logic [QUAL_W-1:0] tuser,
    input wire logic [DATA_W-1:0] tdata,
    input wire logic              int_req,
    input wire logic              int_gnt,
    input wire logic              INT_PEND,
    input wire logic              INT_TAKEN
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // grant seen while asked for, kept until the internal packet is done
    logic gnt_reg;
    always_ff @(posedge CLK)
        gnt_reg <= !RST && !INT_TAKEN && (gnt_reg || (int_req && int_gnt));
    chk_req_cause: assert property ($rose(int_req) |-> $past(INT_PEND))
        else $error("request with nothing pending");
    chk_req_gap: assert property ($fell(int_req) |=> !int_req)
        else $error("request back too soon");
    chk_req_done: assert property ($fell(int_req) |-> INT_TAKEN || $past(INT_TAKEN)
        || $past(INT_TAKEN, 2)) else $error("request dropped before service");
    chk_take_req: assert property (INT_TAKEN |-> int_req || $past(int_req))
        else $error("internal packet sent unasked");
    chk_take_gnt: assert property (INT_TAKEN |-> gnt_reg || int_gnt)
        else $error("internal packet sent without grant");
    chk_beat_hold: assert property (tvalid && !tready |=> tvalid && $stable(tuser)
        && $stable(tdata)) else $error("beat changed before taken");
    chk_no_psn_str: assert property (tvalid |-> !(tuser[QB_POISON] && tuser[QB_STREAMED]))
        else $error("poison on streamed beat");
    chk_auto_gnt: assert property ($past(RST) |-> int_gnt)
        else $error("grant not held after reset");
    cover property ($rose(int_req));
    cover property (INT_TAKEN && !int_gnt);
    cover property (tvalid && !tready);
endmodule
`default_nettype wire

// >>> bench/tx_sideband_arbiter_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tlp_tx_sideband_arbiter_tb import sideband_pkg::*; ;
    typedef struct packed {
        logic [3:0] qf;
        logic [3:0] ql;
        logic [3:0] nb;
        logic [3:0] st;
        logic [3:0] eb;
    } row_t;
    // first-beat and later qualifiers, beats, expected status, beats on the link
    row_t rows [6] = '{'{4'h0, 4'h0, 4'h1, 4'h0, 4'h1}, '{4'h1, 4'h0, 4'h2, 4'h2, 4'h3},
        '{4'h0, 4'h2, 4'h3, 4'h1, 4'h3}, '{4'h4, 4'h0, 4'h2, 4'h4, 4'h2},
        '{4'h6, 4'h0, 4'h1, 4'h4, 4'h1}, '{4'h0, 4'h1, 4'h2, 4'h0, 4'h2}};
    logic              clk, rst, int_pend, link_ready, wr, rd, auto_on;
    logic              link_valid, link_last, int_taken;
    logic [3:0]        addr;
    logic [31:0]       wdata, rdata;
    logic [DATA_W-1:0] link_data;
    logic [ST_W-1:0]   link_status, st;
    int                fail_count = 0, cmp_count = 0, nbeat = 0, pk = 0, taken = 0, p0, t0;
    int                lens [64];
    logic [DATA_W-1:0] last_data [64];
    sideband_if sideband_if_inst ();
    tx_sideband_dev #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) tx_sideband_dev_inst (
        .CLK(clk), .RST(rst), .LNK(sideband_if_inst.dev), .INT_PEND(int_pend),
        .LINK_READY(link_ready), .LINK_DATA(link_data), .LINK_VALID(link_valid),
        .LINK_LAST(link_last), .LINK_STATUS(link_status), .INT_TAKEN(int_taken));
    tx_sideband_usr tx_sideband_usr_inst (.CLK(clk), .RST(rst), .LNK(sideband_if_inst.usr),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
    sideband_checker sideband_checker_inst (.CLK(clk), .RST(rst),
        .tvalid(sideband_if_inst.tvalid), .tready(sideband_if_inst.tready),
        .tuser(sideband_if_inst.tuser), .tdata(sideband_if_inst.tdata),
        .int_req(sideband_if_inst.int_req), .int_gnt(sideband_if_inst.int_gnt),
        .INT_PEND(int_pend), .INT_TAKEN(int_taken));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // link monitor: lengths of finished packets in order
    always @(posedge clk)
    begin
        taken = taken + int'(!rst && int_taken);
        if (!rst && link_valid && link_ready)
            nbeat++;
        if (!rst && link_valid && link_ready && link_last)
        begin
            lens[pk] = nbeat;
            last_data[pk] = link_data;
            st = link_status;
            pk++;
            nbeat = 0;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // one beat through the registers; waits until the stream takes it
    task automatic beat(input logic [3:0] q, input logic lst, input int i);
        int n;
        n = 0;
        wr_reg(A_DATA_LO, 32'(i));
        wr_reg(A_DATA_HI, 32'h0);
        wr_reg(A_QUAL, {28'h0, q});
        wr_reg(A_CTRL, {28'h0, auto_on, 1'b0, lst, 1'b1});
        while (!(sideband_if_inst.tvalid === 1'b1 && sideband_if_inst.tready === 1'b1)
            && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 400)
        begin
            fail_count++;
            $display("mismatch at %0t: beat never taken", $time);
        end
    endtask
    task automatic wait_for(ref int v, input int n);
        int k;
        k = 0;
        while (v < n && k < 400)
        begin
            @(posedge clk);
            k++;
        end
        if (v < n)
        begin
            fail_count++;
            $display("mismatch at %0t: wait ran out", $time);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #2000000;
        fail_count++;
        results();
    end
    initial
    begin
        {rst, int_pend, link_ready, wr, rd, auto_on, addr, wdata} = {6'b101001, 4'h0, 32'h0};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int r = 0; r < 6; r++)
        begin
            p0 = pk;
            for (int i = 0; i < int'(rows[r].nb); i++)
            begin
                beat(i == 0 ? rows[r].qf : rows[r].ql, i == rows[r].nb - 1, i);
                if (i == 0 && rows[r].nb > 1)
                begin
                    repeat (8) @(posedge clk);
                    chk(nbeat != 0, rows[r].qf[QB_STREAMED]);
                end
            end
            wait_for(pk, p0 + 1);
            chk(lens[p0], rows[r].eb);
            chk(last_data[p0][31:0], rows[r].qf[QB_DIGEST] ? DIGEST_WORD : 32'(rows[r].nb - 1));
            chk(st[2:0], rows[r].st[2:0]);
            $display("test row %0d done", r);
        end
        t0 = taken;
        p0 = pk;
        int_pend <= 1'b1;
        @(posedge clk);
        int_pend <= 1'b0;
        wait_for(taken, t0 + 1);
        wait_for(pk, p0 + 1);
        chk(lens[p0], INT_PKT_BEATS);
        chk(last_data[p0][31:0], INT_PKT_WORD[31:0]);
        $display("test auto grant done");
        auto_on = 1'b0;
        wr_reg(A_CTRL, 32'h0);
        t0 = taken;
        p0 = pk;
        int_pend <= 1'b1;
        @(posedge clk);
        int_pend <= 1'b0;
        repeat (9) @(posedge clk);
        rd_chk(A_STATUS, 32'he);
        beat(4'h0, 1'b1, 7);
        wait_for(pk, p0 + 1);
        chk(lens[p0], 1);
        chk(taken, t0);
        // grant given while the link stalls; a user beat queues after it
        link_ready <= 1'b0;
        wr_reg(A_CTRL, 32'h4);
        beat(4'h0, 1'b1, 9);
        repeat (10) @(posedge clk);
        chk(taken, t0);
        link_ready <= 1'b1;
        wait_for(taken, t0 + 1);
        int_pend <= 1'b0;
        wait_for(pk, p0 + 3);
        chk(lens[p0 + 1], INT_PKT_BEATS);
        chk(lens[p0 + 2], 1);
        chk(last_data[p0 + 1][31:0], INT_PKT_WORD[31:0]);
        chk(last_data[p0 + 2][31:0], 32'h9);
        $display("test manual grant done");
        link_ready <= 1'b0;
        p0 = pk;
        for (int i = 0; i < FIFO_DEPTH; i++)
            beat(4'h0, i == FIFO_DEPTH - 1, i);
        wr_reg(A_CTRL, 32'h3);
        repeat (5) @(posedge clk);
        chk({sideband_if_inst.tvalid, sideband_if_inst.tready}, 2'b10);
        link_ready <= 1'b1;
        wait_for(pk, p0 + 2);
        chk(lens[p0], FIFO_DEPTH);
        chk(lens[p0 + 1], 1);
        $display("test buffer full done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(A_STATUS, 32'h2);
        chk(sideband_if_inst.int_gnt, 1'b1);
        $display("test reset done");
        results();
    end
endmodule
`default_nettype wire
